// file: logic/mpp_ports.sv
// multiplexed port pins: ports b, c, d, with peripheral sharing on ports c and d
`timescale 1ns/100ps
`include "mpp_params.svh"

module mpp_ports
  import mpp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire mpp_bus_type bus_in,
  output logic [7:0] rdata_out,
  input wire logic [5:0] port_b_pins_in,
  output logic [5:0] port_b_pins_out,
  output logic [5:0] port_b_pins_oe_n_out,
  output logic [5:0] port_b_pullup_out,
  input wire logic [7:0] port_c_pins_in,
  output logic [7:0] port_c_pins_out,
  output logic [7:0] port_c_pins_oe_n_out,
  output logic [7:0] port_c_pullup_out,
  input wire logic port_d_pin0_in,
  input wire logic port_d_pin1_in,
  output logic port_d_pin0_out,
  output logic port_d_pin1_out,
  output logic [1:0] port_d_pins_oe_n_out,
  output logic [1:0] port_d_pullup_out,
  input wire mpp_periph_out_type periph_in,
  output logic timer_a_count_clock_in_out,
  output logic timer_b_capture_in_out,
  output logic sync_serial_data_in_out,
  output logic sync_serial_clock_in_out,
  output logic sync_serial_select_in_out,
  output logic async_receive_in_out,
  output logic async_baud_clock_in_out,
  output logic [2:0] ext_irq_out
);

  mpp_state_type state;
  mpp_state_type next_state;
  logic [7:0] c_alt;
  logic [7:0] c_alt_oe;
  logic [1:0] d_alt;
  logic [2:0] irq_now;

  // ****************************************
  // helpers
  // ****************************************

  // edge detect for one interrupt line under a selected mode
  function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic now);
    logic rise;
    logic fall;
    rise = now & ~prev;
    fall = prev & ~now;
    case (mpp_edge_type'(sel))
      MPP_EDGE_RISE: edge_hit = rise;
      MPP_EDGE_FALL: edge_hit = fall;
      MPP_EDGE_BOTH: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  // ****************************************
  // peripheral routing
  // ****************************************

  // control-mode drive values and direction overrides per port c bit
  always_comb
  begin
    c_alt = state.c_out;
    c_alt_oe = 8'h00;
    c_alt[`MPP_C_SCK] = periph_in.sck_out;
    c_alt_oe[`MPP_C_SCK] = periph_in.sck_drive;
    // serial out and transmit share one pin; their or-ing is harmless as only one unit runs
    c_alt[`MPP_C_SO] = periph_in.sdo | periph_in.txd;
    c_alt[`MPP_C_TMA] = periph_in.tma_out;
    d_alt[0] = periph_in.tmb_out;
    d_alt[1] = periph_in.buzz;
  end

  // synchronised pin levels always forwarded to peripherals
  assign timer_a_count_clock_in_out = state.c_s2[`MPP_C_TMA];
  assign timer_b_capture_in_out = state.c_s2[`MPP_C_IRQ0 + 2];
  assign sync_serial_data_in_out = state.c_s2[`MPP_C_SI];
  assign sync_serial_clock_in_out = state.c_s2[`MPP_C_SCK];
  assign sync_serial_select_in_out = state.c_s2[`MPP_C_SS];
  assign async_receive_in_out = state.c_s2[`MPP_C_SI];
  assign async_baud_clock_in_out = state.c_s2[`MPP_C_SCK];
  assign irq_now = state.c_s2[`MPP_C_IRQ0 +: 3];

  // ****************************************
  // pin drivers
  // ****************************************

  // direction bits: 1 means input, so oe_n follows the direction bit
  assign port_b_pins_out = state.b_out;
  assign port_b_pins_oe_n_out = state.b_dir;
  assign port_b_pullup_out = state.b_dir & {6{state.spu[`MPP_SPU_B_BIT]}};
  // in control mode the direction bit still rules unless the peripheral forces drive
  assign port_c_pins_out = (state.c_mode & c_alt) | (~state.c_mode & state.c_out);
  assign port_c_pins_oe_n_out = state.c_dir & ~(state.c_mode & c_alt_oe);
  assign port_c_pullup_out = state.c_pu;
  assign port_d_pin0_out = state.d_mode[0] ? d_alt[0] : state.d_out[0];
  assign port_d_pin1_out = state.d_mode[1] ? d_alt[1] : state.d_out[1];
  assign port_d_pins_oe_n_out = state.d_dir;
  assign port_d_pullup_out = state.d_dir & {2{state.spu[`MPP_SPU_D_BIT]}};
  assign ext_irq_out = state.irq;
  assign rdata_out = state.rdata;

  // ****************************************
  // next state
  // ****************************************

  // register writes, reads, synchronisers and edge detection
  always_comb
  begin
    next_state = state;
    next_state.b_s1 = port_b_pins_in;
    next_state.b_s2 = state.b_s1;
    next_state.c_s1 = port_c_pins_in;
    next_state.c_s2 = state.c_s1;
    next_state.d_s1 = {port_d_pin1_in, port_d_pin0_in};
    next_state.d_s2 = state.d_s1;
    next_state.irq_prev = irq_now;
    // one-cycle request pulse, only on pins handed to control mode
    for (int i = 0; i < 3; i++)
    begin
      next_state.irq[i] = state.c_mode[`MPP_C_IRQ0 + i]
        & edge_hit(state.edge_sel[2*i +: 2], state.irq_prev[i], irq_now[i]);
    end
    if (bus_in.wr)
    begin
      if (bus_in.addr == `MPP_ADDR_PORT_B_OUT)
        next_state.b_out = bus_in.wdata[5:0];
      else if (bus_in.addr == `MPP_ADDR_PORT_B_DIR)
        next_state.b_dir = bus_in.wdata[5:0];
      else if (bus_in.addr == `MPP_ADDR_PORT_C_OUT)
        next_state.c_out = bus_in.wdata;
      else if (bus_in.addr == `MPP_ADDR_PORT_C_DIR)
        next_state.c_dir = bus_in.wdata;
      else if (bus_in.addr == `MPP_ADDR_PORT_C_PU)
        next_state.c_pu = bus_in.wdata;
      else if (bus_in.addr == `MPP_ADDR_PORT_C_MODE)
        next_state.c_mode = bus_in.wdata;
      else if (bus_in.addr == `MPP_ADDR_PORT_D_OUT)
        next_state.d_out = bus_in.wdata[1:0];
      else if (bus_in.addr == `MPP_ADDR_PORT_D_DIR)
        next_state.d_dir = bus_in.wdata[1:0];
      else if (bus_in.addr == `MPP_ADDR_PORT_D_MODE)
        next_state.d_mode = bus_in.wdata[1:0];
      else if (bus_in.addr == `MPP_ADDR_SHARED_PU)
        next_state.spu = bus_in.wdata[1:0];
      else if (bus_in.addr == `MPP_ADDR_IRQ_EDGE)
        next_state.edge_sel = bus_in.wdata[5:0];
    end
    next_state.rdata = 8'h00;
    if (bus_in.rd)
    begin
      if (bus_in.addr == `MPP_ADDR_PORT_B_OUT)
        next_state.rdata = {2'h0, state.b_out};
      else if (bus_in.addr == `MPP_ADDR_PORT_B_DIR)
        next_state.rdata = {2'h0, state.b_dir};
      else if (bus_in.addr == `MPP_ADDR_PORT_C_OUT)
        next_state.rdata = state.c_out;
      else if (bus_in.addr == `MPP_ADDR_PORT_C_DIR)
        next_state.rdata = state.c_dir;
      else if (bus_in.addr == `MPP_ADDR_PORT_C_PU)
        next_state.rdata = state.c_pu;
      else if (bus_in.addr == `MPP_ADDR_PORT_C_MODE)
        next_state.rdata = state.c_mode;
      else if (bus_in.addr == `MPP_ADDR_PORT_D_OUT)
        next_state.rdata = {6'h00, state.d_out};
      else if (bus_in.addr == `MPP_ADDR_PORT_D_DIR)
        next_state.rdata = {6'h00, state.d_dir};
      else if (bus_in.addr == `MPP_ADDR_PORT_D_MODE)
        next_state.rdata = {6'h00, state.d_mode};
      else if (bus_in.addr == `MPP_ADDR_SHARED_PU)
        next_state.rdata = {6'h00, state.spu};
      else if (bus_in.addr == `MPP_ADDR_IRQ_EDGE)
        next_state.rdata = {2'h0, state.edge_sel};
      else if (bus_in.addr == `MPP_ADDR_PIN_B)
        next_state.rdata = {2'h0, state.b_s2};
      else if (bus_in.addr == `MPP_ADDR_PIN_C)
        next_state.rdata = state.c_s2;
      else if (bus_in.addr == `MPP_ADDR_PIN_D)
        next_state.rdata = {6'h00, state.d_s2};
      else
        next_state.rdata = 8'h00;
    end
  end

  // ****************************************
  // state register
  // ****************************************

  // all pins inputs, pull-ups and control mode off at reset
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state <= '0;
      state.b_dir <= 6'(`MPP_RESET_DIR_ALL_IN);
      state.c_dir <= `MPP_RESET_DIR_ALL_IN;
      state.d_dir <= 2'h3;
    end
    else
      state <= next_state;
  end

endmodule

// file: logic/mpp_params.svh
// constants for the multiplexed port pin block
`ifndef MPP_PARAMS_SVH
`define MPP_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define MPP_ADDR_PORT_B_OUT 4'h0
`define MPP_ADDR_PORT_B_DIR 4'h1
`define MPP_ADDR_PORT_C_OUT 4'h2
`define MPP_ADDR_PORT_C_DIR 4'h3
`define MPP_ADDR_PORT_C_PU 4'h4
`define MPP_ADDR_PORT_C_MODE 4'h5
`define MPP_ADDR_PORT_D_OUT 4'h6
`define MPP_ADDR_PORT_D_DIR 4'h7
`define MPP_ADDR_PORT_D_MODE 4'h8
`define MPP_ADDR_SHARED_PU 4'h9
`define MPP_ADDR_IRQ_EDGE 4'ha
`define MPP_ADDR_PIN_B 4'hb
`define MPP_ADDR_PIN_C 4'hc
`define MPP_ADDR_PIN_D 4'hd

// ****************************************
// shared pull-up field positions
// ****************************************
`define MPP_SPU_B_BIT 0
`define MPP_SPU_D_BIT 1

// ****************************************
// port c pin sharing positions
// ****************************************
`define MPP_C_SCK 0
`define MPP_C_SO 1
`define MPP_C_SI 2
`define MPP_C_SS 3
`define MPP_C_IRQ0 4
`define MPP_C_TMA 7

// ****************************************
// reset values
// ****************************************
`define MPP_RESET_DIR_ALL_IN 8'hff
`define MPP_RESET_ZERO 8'h00

`endif

// file: logic/mpp_pkg.sv
// types for the multiplexed port pin block
package mpp_pkg;

  // edge selection per external interrupt
  typedef enum logic [1:0] {
    MPP_EDGE_NONE,
    MPP_EDGE_RISE,
    MPP_EDGE_FALL,
    MPP_EDGE_BOTH
  } mpp_edge_type;

  // bus request towards the register file
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } mpp_bus_type;

  // peripheral signals going out to the pins
  typedef struct packed {
    logic sck_out;
    logic sck_drive;
    logic sdo;
    logic txd;
    logic tma_out;
    logic tmb_out;
    logic buzz;
  } mpp_periph_out_type;

  // whole state of the block
  typedef struct packed {
    logic [5:0] b_out;
    logic [5:0] b_dir;
    logic [7:0] c_out;
    logic [7:0] c_dir;
    logic [7:0] c_pu;
    logic [7:0] c_mode;
    logic [1:0] d_out;
    logic [1:0] d_dir;
    logic [1:0] d_mode;
    logic [1:0] spu;
    logic [5:0] edge_sel;
    logic [5:0] b_s1;
    logic [5:0] b_s2;
    logic [7:0] c_s1;
    logic [7:0] c_s2;
    logic [1:0] d_s1;
    logic [1:0] d_s2;
    logic [2:0] irq_prev;
    logic [2:0] irq;
    logic [7:0] rdata;
  } mpp_state_type;

endpackage

// file: verif/mpp_ports_chk.sv
// checker of pin-level rules for the multiplexed port block
`timescale 1ns/100ps
module mpp_ports_chk
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [5:0] port_b_pins_oe_n_out,
  input wire logic [5:0] port_b_pullup_out,
  input wire logic [7:0] port_c_pins_in,
  input wire logic [7:0] port_c_pins_oe_n_out,
  input wire logic [7:0] port_c_pullup_out,
  input wire logic [1:0] port_d_pins_oe_n_out,
  input wire logic [1:0] port_d_pullup_out,
  input wire logic timer_a_count_clock_in_out,
  input wire logic timer_b_capture_in_out,
  input wire logic sync_serial_select_in_out,
  input wire logic [2:0] ext_irq_out
);
  // edges since reset; pin history is trusted only once the pipe is full
  logic [2:0] age;
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      age <= 3'h0;
    else if (age != 3'h7)
      age <= age + 3'h1;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  AST_B_PU: assert property ((port_b_pullup_out & ~port_b_pins_oe_n_out) == 6'h00)
    else $error("port b pull-up on a driven pin");
  AST_D_PU: assert property ((port_d_pullup_out & ~port_d_pins_oe_n_out) == 2'h0)
    else $error("port d pull-up on a driven pin");
  AST_RST_OE: assert property ($rose(rstn_in) |-> &{port_b_pins_oe_n_out, port_c_pins_oe_n_out, port_d_pins_oe_n_out})
    else $error("pin driven right after reset");
  AST_RST_PU: assert property ($rose(rstn_in) |-> {port_b_pullup_out, port_c_pullup_out, port_d_pullup_out} == 16'h0000)
    else $error("pull-up on right after reset");
  AST_FWD: assert property (age == 3'h7 |-> {timer_a_count_clock_in_out, timer_b_capture_in_out,
    sync_serial_select_in_out} == $past({port_c_pins_in[7], port_c_pins_in[6], port_c_pins_in[3]}, 2))
    else $error("forwarded input not two cycles behind pin");
  AST_IRQ0: assert property (age == 3'h7 && ext_irq_out[0] |-> $past(port_c_pins_in[4], 3) != $past(port_c_pins_in[4], 4))
    else $error("irq 0 without pin edge");
  AST_IRQ1: assert property (age == 3'h7 && ext_irq_out[1] |-> $past(port_c_pins_in[5], 3) != $past(port_c_pins_in[5], 4))
    else $error("irq 1 without pin edge");
  AST_IRQ2: assert property (age == 3'h7 && ext_irq_out[2] |-> $past(port_c_pins_in[6], 3) != $past(port_c_pins_in[6], 4))
    else $error("irq 2 without pin edge");
endmodule
bind mpp_ports mpp_ports_chk u_chk (.clk_in(clk_in), .rstn_in(rstn_in), .port_b_pins_oe_n_out(port_b_pins_oe_n_out),
  .port_b_pullup_out(port_b_pullup_out), .port_c_pins_in(port_c_pins_in), .port_c_pins_oe_n_out(port_c_pins_oe_n_out),
  .port_c_pullup_out(port_c_pullup_out), .port_d_pins_oe_n_out(port_d_pins_oe_n_out),
  .port_d_pullup_out(port_d_pullup_out), .timer_a_count_clock_in_out(timer_a_count_clock_in_out),
  .timer_b_capture_in_out(timer_b_capture_in_out), .sync_serial_select_in_out(sync_serial_select_in_out),
  .ext_irq_out(ext_irq_out));

// file: verif/mpp_board.sv
// board model: resolves each pin from device drive, board drive and pull-up
`timescale 1ns/100ps
module mpp_board #(parameter int W = 8)
(
  input wire logic clk_in,
  input wire logic [W-1:0] drv_in,
  input wire logic [W-1:0] oe_n_in,
  input wire logic [W-1:0] pu_in,
  input wire logic [W-1:0] ext_in,
  input wire logic [W-1:0] ext_en_in,
  output logic [W-1:0] lvl_out
);
  // a floating pin toggles, so a stale level is never mistaken for a read
  logic [W-1:0] prev = '0;
  assign lvl_out = (~oe_n_in & drv_in) | (oe_n_in & ext_en_in & ext_in) | (oe_n_in & ~ext_en_in & (pu_in | ~prev));
  always_ff @(posedge clk_in) prev <= lvl_out;
endmodule

// file: verif/test_mpp_ports.sv
// self-checking bench for the multiplexed port block
`timescale 1ns/100ps
`include "mpp_params.svh"
module test_mpp_ports;
  import mpp_pkg::*;
  logic clk_in = 0;
  logic rstn_in = 0;
  mpp_bus_type bus = '0;
  mpp_periph_out_type per = '0;
  logic [7:0] rdata, c_pin, c_out, c_oe, c_pu;
  logic [7:0] ext_c = 0;
  logic [7:0] en_c = 0;
  logic [5:0] ext_b = 0;
  logic [5:0] en_b = 0;
  logic [1:0] ext_d = 0;
  logic [1:0] en_d = 0;
  logic [5:0] b_pin, b_out, b_oe, b_pu;
  logic [1:0] d_pin, d_out, d_oe, d_pu;
  logic [2:0] irq;
  logic [6:0] fwd;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  int n_irq = 0;
  always #10 clk_in = ~clk_in;
  mpp_ports DUT (.clk_in(clk_in), .rstn_in(rstn_in), .bus_in(bus), .rdata_out(rdata), .port_b_pins_in(b_pin),
    .port_b_pins_out(b_out), .port_b_pins_oe_n_out(b_oe), .port_b_pullup_out(b_pu), .port_c_pins_in(c_pin),
    .port_c_pins_out(c_out), .port_c_pins_oe_n_out(c_oe), .port_c_pullup_out(c_pu), .port_d_pin0_in(d_pin[0]),
    .port_d_pin1_in(d_pin[1]), .port_d_pin0_out(d_out[0]), .port_d_pin1_out(d_out[1]), .port_d_pins_oe_n_out(d_oe),
    .port_d_pullup_out(d_pu), .periph_in(per), .timer_a_count_clock_in_out(fwd[6]), .timer_b_capture_in_out(fwd[5]),
    .sync_serial_data_in_out(fwd[4]), .sync_serial_clock_in_out(fwd[3]), .sync_serial_select_in_out(fwd[2]),
    .async_receive_in_out(fwd[1]), .async_baud_clock_in_out(fwd[0]), .ext_irq_out(irq));
  mpp_board #(.W(6)) u_bb (.clk_in(clk_in), .drv_in(b_out), .oe_n_in(b_oe), .pu_in(b_pu), .ext_in(ext_b),
    .ext_en_in(en_b), .lvl_out(b_pin));
  mpp_board #(.W(8)) u_bc (.clk_in(clk_in), .drv_in(c_out), .oe_n_in(c_oe), .pu_in(c_pu), .ext_in(ext_c),
    .ext_en_in(en_c), .lvl_out(c_pin));
  mpp_board #(.W(2)) u_bd (.clk_in(clk_in), .drv_in(d_out), .oe_n_in(d_oe), .pu_in(d_pu), .ext_in(ext_d),
    .ext_en_in(en_d), .lvl_out(d_pin));
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // cycle ceiling and interrupt pulse count
  always @(posedge clk_in)
  begin
    cyc++;
    n_irq += $countones(irq);
    if (cyc == 4000)
    begin
      n_fail++;
      test_done;
    end
  end
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_in) bus <= '0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string s);
    @(posedge clk_in) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_in) bus <= '0;
    #1 chk(s, e, rdata);
  endtask
  task automatic settle;
    repeat (3) @(posedge clk_in);
    #1;
  endtask
  task automatic t_reset;
    chk("oe b d", 8'hff, {b_oe, d_oe});
    chk("oe c", 8'hff, c_oe);
    chk("pu c", 8'h00, c_pu);
    rd(`MPP_ADDR_PORT_C_MODE, 8'h00, "c mode");
    wr(4'hf, 8'h55);
    rd(4'hf, 8'h00, "unmapped");
  endtask
  task automatic t_ports;
    wr(`MPP_ADDR_PORT_B_DIR, 8'h3c);
    wr(`MPP_ADDR_PORT_B_OUT, 8'h15);
    wr(`MPP_ADDR_SHARED_PU, 8'h01);
    wr(`MPP_ADDR_PORT_C_DIR, 8'hf0);
    wr(`MPP_ADDR_PORT_C_PU, 8'h0f);
    wr(`MPP_ADDR_PORT_C_OUT, 8'ha5);
    settle;
    chk("b oe", 8'h3c, {2'b00, b_oe});
    chk("b pu", 8'h3c, {2'b00, b_pu});
    rd(`MPP_ADDR_PIN_B, 8'h3d, "b pins");
    chk("c oe", 8'hf0, c_oe);
    chk("c pu", 8'h0f, c_pu);
    chk("c out", 8'ha5, c_out);
  endtask
  // serial clock pin flips to a drive when the peripheral takes it
  task automatic t_ctrl;
    wr(`MPP_ADDR_PORT_C_DIR, 8'h7f);
    wr(`MPP_ADDR_PORT_C_MODE, 8'h83);
    wr(`MPP_ADDR_PORT_D_DIR, 8'h00);
    wr(`MPP_ADDR_PORT_D_MODE, 8'h03);
    for (int v = 0; v < 2; v++)
    begin
      per <= v ? 7'h12 : 7'h6d;
      settle;
      chk("c oe ctl", v ? 8'h7f : 8'h7e, c_oe);
      chk("c out ctl", v ? 8'h02 : 8'h83, c_out & 8'h83);
      chk("d out ctl", v ? 8'h01 : 8'h02, {6'h00, d_out});
    end
    wr(`MPP_ADDR_PORT_D_DIR, 8'h03);
    wr(`MPP_ADDR_SHARED_PU, 8'h02);
    settle;
    chk("d pu b pu", 8'h03, {b_pu, d_pu});
  endtask
  task automatic t_fwd;
    logic [7:0] p;
    wr(`MPP_ADDR_PORT_C_DIR, 8'hff);
    en_c <= 8'hff;
    for (int v = 0; v < 2; v++)
    begin
      p = v ? 8'h5a : 8'ha5;
      ext_c <= p;
      settle;
      chk("fwd", {1'b0, p[7], p[6], p[2], p[0], p[3], p[2], p[0]}, {1'b0, fwd});
      rd(`MPP_ADDR_PIN_C, p, "c pins");
    end
    ext_c <= 8'h00;
    // board drives the input bits of ports b and d; driven bits keep the latch
    ext_b <= 6'h2a;
    en_b <= 6'h3f;
    ext_d <= 2'h2;
    en_d <= 2'h3;
    settle;
    rd(`MPP_ADDR_PIN_B, 8'h29, "b pins ext");
    rd(`MPP_ADDR_PIN_D, 8'h02, "d pins ext");
  endtask
  task automatic pulse(input int i, input logic [7:0] e);
    repeat (4) @(posedge clk_in);
    #1 n_irq = 0;
    ext_c[4+i] <= 1'b1;
    repeat (6) @(posedge clk_in);
    ext_c[4+i] <= 1'b0;
    settle;
    settle;
    chk("irq pulses", e, 8'(n_irq));
  endtask
  task automatic t_irq;
    wr(`MPP_ADDR_PORT_C_MODE, 8'h00);
    wr(`MPP_ADDR_IRQ_EDGE, 8'h3f);
    pulse(0, 8'h00);
    wr(`MPP_ADDR_PORT_C_MODE, 8'h70);
    for (int i = 0; i < 3; i++)
      for (int c = 0; c < 4; c++)
      begin
        wr(`MPP_ADDR_IRQ_EDGE, 8'(c) << (2 * i));
        pulse(i, 8'(c % 2 + c / 2));
      end
  endtask
  initial
  begin
    repeat (6) @(posedge clk_in);
    rstn_in <= 1'b1;
    #1 t_reset;
    t_ports;
    t_ctrl;
    t_fwd;
    t_irq;
    test_done;
  end
endmodule
